// >>> src/cfg_pair_pkg.sv
// package for the configuration register pair: offsets, fields, timing
// assumes a 10 MHz core clock and a word-wide register access port
package cfg_pair_pkg;
  localparam logic [7:0] off_pin_bus = 8'h00_a6;
  localparam logic [7:0] off_clk_sleep = 8'h00_a8;
  localparam logic [31:0] reset_value = 32'h0000_0000;
  // writable bits of each register, the rest read as zero
  localparam logic [31:0] mask_pin_bus = 32'h0ff0_001f;
  localparam logic [31:0] mask_clk_sleep = 32'h7fff_ffff;
  // field positions
  localparam int monitor_bit = 27;
  localparam int addr_lsb = 20;
  localparam int drive_lsb = 3;
  localparam int pullup_bit = 2;
  localparam int range_lsb = 0;
  localparam int fmax_lsb = 16;
  localparam int sleep_lsb = 14;
  localparam int wd_int_lsb = 2;
  localparam int wd_en_bit = 4;
  localparam int wd_src_bit = 1;
  localparam int wd_act_bit = 0;
  // timing in own units, converted to 100 ns cycles
  localparam int clk_mhz = 10;
  localparam int sleep_us [4] = '{50, 200, 20000, 200000};
  localparam int wd_gpio_ms [4] = '{100, 200, 500, 1000};
  localparam int wd_bus_ms [4] = '{1000, 2000, 3000, 10000};
  localparam int us_cycles = clk_mhz;
  localparam int ms_cycles = clk_mhz * 1000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage

// >>> src/device_config_register_pair.sv
// configuration register pair with sleep timer, watchdog and speed duty
// assumes synchronous inputs and a single-cycle register access port
// assumes reads and writes arrive as one-cycle strobes on req
// long timer counts may be shortened by tick_scale for simulation
`timescale 1ns/1ps
module device_config_register_pair
  import cfg_pair_pkg::*;
#(
  // duty resolution and timer scaling
  parameter int duty_w = 16,
  parameter int tick_scale = 1 // divides long counts for simulation
) (
  // clock and reset
  input wire logic clk, // 10 MHz clock
  input wire logic resetn, // synchronous reset, active low

  // register access port, one-cycle strobes
  input wire reg_req_t req, // register read or write request

  // speed and watchdog inputs
  // watchdog tickles are one-cycle pulses
  input wire logic [14:0] freq_meas, // measured speed input frequency
  input wire logic freq_mode, // speed input is in frequency mode
  input wire logic speed_pin, // speed command pin level
  input wire logic tickle_gpio, // watchdog tickle pulse from pin
  input wire logic tickle_bus, // watchdog tickle pulse from bus
  input wire logic fault_clear, // clears a latched watchdog fault

  // read return
  output logic [31:0] rdata, // read data
  output logic rvalid, // read data valid pulse

  // first register fields, driven from flops
  output logic monitor_output_pin_en, // analog monitor enable
  output logic [6:0] target_addr, // serial-bus target address
  output logic [1:0] drive_code, // serial-bus pin drive strength
  output logic pullup_en, // fault and feedback pull-ups
  output logic [1:0] dc_supply_range, // max dc supply code

  // derived controls
  output logic [duty_w-1:0] duty, // commanded duty, full = all ones
  output logic sleep_req, // sleep entry request
  output logic wd_fault, // watchdog fault report
  output logic outputs_hiz // power stage held in high impedance
);
  // refuse widths the divider and outputs cannot serve
  initial begin
    if (duty_w < 1 || duty_w > 32 || tick_scale < 1)
      $error("unsupported parameters");
  end

  // all state of the block in one record
  typedef struct packed {
    // register images
    logic [31:0] cfg1;
    logic [31:0] cfg2;
    // read return
    logic [31:0] rdata;
    logic rvalid;
    // timers, in clk cycles
    logic [31:0] low_cnt;
    logic [31:0] wd_cnt;
    // derived controls
    logic [duty_w-1:0] duty;
    logic sleep;
    logic fault;
    logic hiz;
  } state_t;

  // registered state and its next value
  state_t q, next_q;
  // limits and quotient from the current setup
  logic [31:0] sleep_lim, wd_lim;
  logic [31:0] quot;

  // sleep limit in cycles from the entry time code
  // counts are in 100 ns cycles of clk
  // hazard: a zero limit makes sleep follow a single low cycle
  always_comb begin
    sleep_lim = 32'(sleep_us[q.cfg2[sleep_lsb+:2]] * us_cycles
                / tick_scale);
  end

  // watchdog limit; bit 1 picks the pin or the bus interval
  // the bus intervals are ten times longer than the pin ones, except code 2 (3000 ms against 500 ms)
  always_comb begin
    if (q.cfg2[wd_src_bit])
      wd_lim = 32'(wd_gpio_ms[q.cfg2[wd_int_lsb+:2]] * ms_cycles
               / tick_scale);
    else
      wd_lim = 32'(wd_bus_ms[q.cfg2[wd_int_lsb+:2]] * ms_cycles
               / tick_scale);
  end

  // duty quotient; a zero full scale reads as saturated
  // shift first so the fraction keeps duty_w bits
  always_comb begin
    if (q.cfg2[fmax_lsb+:15] == 15'h0000)
      quot = 32'hffff_ffff;
    else
      quot = ({17'h0_0000, freq_meas} << duty_w)
             / {17'h0_0000, q.cfg2[fmax_lsb+:15]};
  end

  // next state
  // everything is computed from q and the inputs of this cycle
  always_comb begin
    next_q = q;

    // read strobe becomes the valid pulse one cycle later
    next_q.rvalid = req.rd;
    // read data holds until the next read
    if (req.rd) begin
      // unmapped offsets answer zero
      case (req.addr)
        off_pin_bus: next_q.rdata = q.cfg1;
        off_clk_sleep: next_q.rdata = q.cfg2;
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    // writes keep only the writable bits; a read in the same cycle
    // still returns the old word
    if (req.wr && req.addr == off_pin_bus)
      next_q.cfg1 = req.wdata & mask_pin_bus;
    if (req.wr && req.addr == off_clk_sleep)
      next_q.cfg2 = req.wdata & mask_clk_sleep;

    // duty saturates when input exceeds full scale
    // outside frequency mode the last duty is kept
    if (freq_mode) begin
      if (quot >= (33'h1_0000_0000 >> (32 - duty_w)))
        next_q.duty = '1;
      else
        next_q.duty = quot[duty_w-1:0];
    end

    // sleep timer on continuous low speed pin
    // the count stops one below the limit so it cannot wrap
    if (speed_pin) begin
      next_q.low_cnt = 32'h0000_0000;
      next_q.sleep = 1'b0;
    end else if (q.low_cnt + 32'h0000_0001 >= sleep_lim) begin
      next_q.sleep = 1'b1;
    end else begin
      next_q.low_cnt = q.low_cnt + 32'h0000_0001;
    end

    // external watchdog
    // a tickle or a disabled watchdog restarts the count
    // report mode drops the report on a fresh tickle
    if (!q.cfg2[wd_en_bit] ||
        (q.cfg2[wd_src_bit] ? tickle_gpio : tickle_bus)) begin
      next_q.wd_cnt = 32'h0000_0000;
      if (!q.cfg2[wd_act_bit])
        next_q.fault = 1'b0;
    end else if (q.wd_cnt + 32'h0000_0001 >= wd_lim) begin
      // a miss restarts the count so a later miss is seen too
      next_q.wd_cnt = 32'h0000_0000;
      next_q.fault = 1'b1;
      next_q.hiz = q.cfg2[wd_act_bit];
    end else begin
      next_q.wd_cnt = q.wd_cnt + 32'h0000_0001;
    end

    // latched fault cleared by request; a new miss wins
    // clearing and missing in one cycle leaves the fault set only if it was clear before that cycle
    if (fault_clear && !(next_q.fault && !q.fault)) begin
      next_q.fault = 1'b0;
      next_q.hiz = 1'b0;
    end
  end

  // state register
  // synchronous reset; register images are named to show their value
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.cfg1 <= reset_value;
      q.cfg2 <= reset_value;
    end else begin
      q <= next_q;
    end
  end

  // read port
  assign rdata = q.rdata;
  assign rvalid = q.rvalid;

  // first register fields straight from the flops
  assign monitor_output_pin_en = q.cfg1[monitor_bit];
  assign target_addr = q.cfg1[addr_lsb+:7];
  assign drive_code = q.cfg1[drive_lsb+:2];
  assign pullup_en = q.cfg1[pullup_bit];
  assign dc_supply_range = q.cfg1[range_lsb+:2];

  // derived controls, also registered
  assign duty = q.duty;
  assign sleep_req = q.sleep;
  assign wd_fault = q.fault;
  assign outputs_hiz = q.hiz;
endmodule

// >>> test/cfg_pair_chk.sv
// checker for the register pair
// assumes it is bound to the top module
`timescale 1ns/1ps
module cfg_pair_chk
  import cfg_pair_pkg::*;
(
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire reg_req_t req, // request
  input wire logic [31:0] rdata, // data
  input wire logic rvalid, // valid
  input wire logic monitor_output_pin_en, // monitor
  input wire logic [6:0] target_addr, // address
  input wire logic [1:0] drive_code, // drive
  input wire logic pullup_en, // pull-ups
  input wire logic [1:0] dc_supply_range // range
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // write to the first word
  wire w = req.wr && req.addr == off_pin_bus;
  wire [31:0] d = req.wdata;
  rd_pulse_a: assert property (rvalid == $past(req.rd))
    else $error("bad rvalid");
  rst_zero_a: assert property (!$past(resetn) |-> rdata == 0)
    else $error("bad reset");
  mon_en_a: assert property (w |=> monitor_output_pin_en == $past(d[27]))
    else $error("bad monitor");
  tgt_addr_a: assert property (w |=> target_addr == $past(d[26:20]))
    else $error("bad address");
  drive_a: assert property (w |=> drive_code == $past(d[4:3]))
    else $error("bad drive");
  pullup_a: assert property (w |=> pullup_en == $past(d[2]))
    else $error("bad pullup");
  range_a: assert property (w |=> dc_supply_range == $past(d[1:0]))
    else $error("bad range");
  resv_lo_a: assert property (req.rd |=> rdata[31] == 1'b0)
    else $error("bad reserved");
  resv_pin_a: assert property (req.rd && req.addr == off_pin_bus |=>
    (rdata & ~mask_pin_bus) == 32'h0000_0000)
    else $error("bad reserved pin word");
  cover property (w);
  cover property (req.rd && req.addr == off_clk_sleep);
  cover property (req.rd && req.wr);
endmodule
bind device_config_register_pair cfg_pair_chk chk (.*);

// >>> test/device_config_register_pair_tb.sv
// bench for the register pair
// assumes single-cycle requests taken at rising edges
`timescale 1ns/1ps
module device_config_register_pair_tb;
  import cfg_pair_pkg::*;
  logic clk = 0, resetn = 0, freq_mode = 0, speed_pin = 1;
  logic tickle_gpio = 0, tickle_bus = 0, fault_clear = 0, rvalid;
  logic monitor_output_pin_en, pullup_en, sleep_req, wd_fault, outputs_hiz;
  logic [14:0] freq_meas = 0;
  logic [31:0] rdata;
  logic [15:0] duty;
  logic [6:0] target_addr;
  logic [1:0] drive_code, dc_supply_range;
  reg_req_t req = '0;
  int n_errors = 0, compares = 0;
  device_config_register_pair #(.tick_scale(1000)) dut (.*);
  initial forever #50 clk = ~clk;
  task automatic chk(string s, logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // one request cycle, then idle
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk) req <= '0;
    @(negedge clk) chk("rvalid", 32'h0000_0001, rvalid);
    chk("rdata", e, rdata);
  endtask
  task automatic t_pins;
    rd(off_pin_bus, 0);
    wr(off_pin_bus, '1);
    rd(off_pin_bus, 32'h0ff0_001f);
    wr(off_pin_bus, 32'h0530_0012);
    @(negedge clk) chk("pins", 13'h0a72, {monitor_output_pin_en,
      target_addr, drive_code, pullup_en, dc_supply_range});
    $display("pins done");
  endtask
  task automatic t_duty;
    rd(off_clk_sleep, 0);
    wr(off_clk_sleep, '1);
    rd(off_clk_sleep, 32'h7fff_ffff);
    rd(8'h00_a4, 0);
    wr(off_clk_sleep, 32'h0064_0000);
    freq_meas <= 15'h0032;
    freq_mode <= 1'b1;
    repeat (4) @(negedge clk);
    chk("duty", 16'h8000, duty);
    @(posedge clk) freq_meas <= 15'h00c8;
    repeat (4) @(negedge clk);
    chk("sat", 16'hffff, duty);
    $display("duty done");
  endtask
  task automatic t_sleep;
    wr(off_clk_sleep, 32'h0000_8000);
    speed_pin <= 0;
    repeat (150) @(negedge clk);
    chk("early", 0, sleep_req);
    repeat (100) @(negedge clk);
    chk("sleep", 1, sleep_req);
    $display("sleep done");
  endtask
  task automatic t_wd;
    wr(off_clk_sleep, 32'h0000_0013);
    repeat (900) @(negedge clk);
    chk("early", 0, wd_fault);
    repeat (300) @(negedge clk);
    chk("hiz", 3, {wd_fault, outputs_hiz});
    @(posedge clk) fault_clear <= 1'b1;
    @(posedge clk) fault_clear <= 1'b0;
    @(negedge clk) chk("clear", 0, {wd_fault, outputs_hiz});
    $display("watchdog done");
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1;
    t_pins;
    t_duty;
    t_sleep;
    t_wd;
    tally_and_finish;
  end
  // hang guard, about ten times the expected run
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
endmodule
